// file: bench/single_wire_bit_frame_link_tb.sv
// Testbench: host model against the client, with a byte-level reference model
`timescale 1ns/1ps
`default_nettype none
module single_wire_bit_frame_link_tb;
  import swl_pkg::*;
  logic       ref_clk_in, reset_in, std_speed_in, busy_in, rx_ack_in;
  logic [7:0] tx_byte_in, rx_byte_out, b;
  logic       line_out, line_oe_out, discovered_out, start_out, rx_valid_out, rx_first_out;
  logic       tx_load_out, tx_nack_out, line_reset_out, host_low, s;
  logic [3:0] opcode_out;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  wire logic  line_w;
  int         n_fail, comparisons, n_start, n_lrst, n_nack, n_load;
  integer     seed;
  // Pull-up wins unless someone pulls low
  assign line_w = !(host_low || line_oe_out);
  swl_host_model host (.ref_clk_in(ref_clk_in), .line_in(line_w), .drive_low_out(host_low));
  swl_client #(.RESET_CYCLES_HS(400), .RESET_CYCLES_STD(2000), .HIGH_CYCLES_HS(500),
    .HIGH_CYCLES_STD(2000)) dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .line_in(line_w), .line_out(line_out), .line_oe_out(line_oe_out),
    .std_speed_in(std_speed_in), .busy_in(busy_in), .tx_byte_in(tx_byte_in),
    .rx_ack_in(rx_ack_in), .discovered_out(discovered_out), .start_out(start_out),
    .rx_byte_out(rx_byte_out), .rx_valid_out(rx_valid_out), .rx_first_out(rx_first_out),
    .opcode_out(opcode_out), .tx_load_out(tx_load_out), .tx_nack_out(tx_nack_out),
    .line_reset_out(line_reset_out));
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic finish_test;
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // Eight input frames MSB first, then a read frame for the client's answer
  task automatic send_byte(input logic [7:0] v, input logic first, input logic ack,
                           input logic std);
    int len;
    len = std ? 1600 : 400;
    exp_q.push_back({first, v});
    for (int i = 7; i >= 0; i--) begin
      host.frame(v[i] ? (std ? 120 : 30) : (std ? 800 : 200), 0, len, s);
    end
    host.frame(std ? 80 : 20, std ? 140 : 35, len, s);
    check(s, !ack, "ack frame");
  endtask : send_byte
  always @(posedge ref_clk_in) begin
    if (rx_valid_out === 1'b1) begin
      e = exp_q.pop_front();
      check({rx_first_out, rx_byte_out}, e, "received byte");
    end
    n_start += (start_out === 1'b1);
    n_lrst  += (line_reset_out === 1'b1);
    n_nack  += (tx_nack_out === 1'b1);
    n_load  += (tx_load_out === 1'b1);
  end
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    finish_test;
  end
  initial begin
    seed = 32'hbd96_a36c;
    reset_in = 1'b1;
    std_speed_in = 1'b0;
    busy_in = 1'b0;
    rx_ack_in = 1'b1;
    tx_byte_in = 8'h00;
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    host.frame(500, 0, 700, s);
    check(n_lrst, 1, "line reset pulses");
    // A busy client needs the longer discharge low before it resets
    busy_in <= 1'b1;
    host.frame(500, 0, 700, s);
    check(n_lrst, 1, "short low while busy");
    host.frame(3100, 0, 3300, s);
    check(n_lrst, 2, "discharge reset");
    busy_in <= 1'b0;
    host.frame(20, 80, 600, s);
    check(s, 1'b0, "discovery answer");
    check(discovered_out, 1'b1, "discovered");
    host.idle(600);
    check(n_start, 1, "start pulses");
    b = 8'($random(seed));
    send_byte({b[7:1], 1'b0}, 1'b1, 1'b1, 1'b0);
    check(opcode_out, b[7:4], "opcode");
    // A short glitch between frames must not open a frame
    host.frame(6, 0, 100, s);
    @(posedge ref_clk_in) rx_ack_in <= 1'b0;
    send_byte(8'($random(seed)), 1'b0, 1'b0, 1'b0);
    host.idle(600);
    @(posedge ref_clk_in) rx_ack_in <= 1'b1;
    // The byte to send is taken at the acknowledge of the command byte
    tx_byte_in <= 8'($random(seed));
    b = 8'($random(seed));
    send_byte({b[7:1], 1'b1}, 1'b1, 1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      host.frame(20, 35, 400, s);
      check(s, tx_byte_in[i], "read bit");
    end
    host.frame(30, 0, 400, s);
    check(n_nack, 1, "host nack seen");
    check(n_load, 1, "transmit loads");
    // Standard speed: longer start time, frames and sample point
    std_speed_in <= 1'b1;
    host.idle(2100);
    b = 8'($random(seed));
    send_byte({b[7:1], 1'b0}, 1'b1, 1'b1, 1'b1);
    check(exp_q.size(), 0, "bytes outstanding");
    finish_test;
  end
endmodule : single_wire_bit_frame_link_tb
`default_nettype wire

// file: bench/swl_client_assertions.sv
// Checker: port-level timing relations of the single-wire link client
`timescale 1ns/1ps
`default_nettype none
module swl_client_checker
  import swl_pkg::*;
#(
  parameter int unsigned RESET_CYCLES_HS = RESET_HS_CYC,
  parameter int unsigned HIGH_CYCLES_HS  = HIGH_HS_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       line_in,
  input  wire logic       line_out,
  input  wire logic       line_oe_out,
  input  wire logic       discovered_out,
  input  wire logic       start_out,
  input  wire logic [7:0] rx_byte_out,
  input  wire logic       rx_valid_out,
  input  wire logic       rx_first_out,
  input  wire logic [3:0] opcode_out,
  input  wire logic       line_reset_out
);
  logic [15:0] oe_len_r, oe_len_nxt, low_run_r, low_run_nxt, high_run_r, high_run_nxt;
  logic        line_d_r;
  always_comb begin
    oe_len_nxt   = line_oe_out ? oe_len_r + 16'h0001 : 16'h0000;
    low_run_nxt  = line_in ? low_run_r : (line_d_r ? 16'h0001 : low_run_r + 16'h0001);
    high_run_nxt = !line_in ? high_run_r : (!line_d_r ? 16'h0001 : high_run_r + 16'h0001);
  end
  always_ff @(posedge ref_clk_in) begin
    oe_len_r   <= reset_in ? 16'h0000 : oe_len_nxt;
    low_run_r  <= reset_in ? 16'h0000 : low_run_nxt;
    high_run_r <= reset_in ? 16'h0000 : high_run_nxt;
    line_d_r   <= reset_in ? 1'b1 : line_in;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_od_data_low: assert property (line_oe_out |-> line_out == 1'b0)
    else $error("line driven high");
  a_drive_after_fall: assert property ($rose(line_oe_out) |-> !$past(line_in, 12))
    else $error("client drive without host falling edge");
  a_drive_len: assert property ($fell(line_oe_out) |-> oe_len_r >= 40 && oe_len_r <= 480)
    else $error("client low drive length out of range");
  a_reset_quiet: assert property ($fell(reset_in) |-> !line_oe_out && !discovered_out)
    else $error("client active right after reset");
  a_opcode_first: assert property (rx_valid_out && rx_first_out |=>
    opcode_out == rx_byte_out[7:4])
    else $error("opcode not upper nibble of first byte");
  a_reset_low_len: assert property (line_reset_out |-> low_run_r >= RESET_CYCLES_HS)
    else $error("line reset on short low");
  a_start_high_len: assert property (start_out |-> high_run_r >= HIGH_CYCLES_HS)
    else $error("start on short high");
  a_valid_pulse: assert property (rx_valid_out |=> !rx_valid_out)
    else $error("receive strobe longer than one cycle");
  c_first_byte: cover property (rx_valid_out && rx_first_out);
  c_line_reset: cover property (line_reset_out);
  c_discovered: cover property ($rose(discovered_out));
endmodule : swl_client_checker
bind swl_client swl_client_checker #(.RESET_CYCLES_HS(RESET_CYCLES_HS),
  .HIGH_CYCLES_HS(HIGH_CYCLES_HS)) u_chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .line_in(line_in), .line_out(line_out), .line_oe_out(line_oe_out),
  .discovered_out(discovered_out), .start_out(start_out), .rx_byte_out(rx_byte_out),
  .rx_valid_out(rx_valid_out), .rx_first_out(rx_first_out), .opcode_out(opcode_out),
  .line_reset_out(line_reset_out));
`default_nettype wire

// file: bench/swl_host_model.sv
// Host model: drives the open-drain line low in timed bit frames
`timescale 1ns/1ps
`default_nettype none
module swl_host_model (
  input  wire logic ref_clk_in,
  input  wire logic line_in,
  output logic      drive_low_out
);
  initial drive_low_out = 1'b0;
  // Every frame opens with a host falling edge; frames run back to back
  task automatic frame(input int low_c, input int smp_c, input int len,
                       output logic smp);
    for (int i = 0; i < len; i++) begin
      @(posedge ref_clk_in);
      if (i == smp_c) smp = line_in;
      drive_low_out <= (i < low_c);
    end
  endtask : frame
  // Released line with no frame: recovery, start and stop high time
  task automatic idle(input int len);
    repeat (len) @(posedge ref_clk_in);
  endtask : idle
endmodule : swl_host_model
`default_nettype wire

// file: logic/swl_client.sv
// Single-wire bit-frame link client: reset, discovery, bit frames and byte framing
`timescale 1ns/1ps
`default_nettype none
module swl_client
  import swl_pkg::*;
#(
  parameter int unsigned RESET_CYCLES_HS  = RESET_HS_CYC,
  parameter int unsigned RESET_CYCLES_STD = RESET_STD_CYC,
  parameter int unsigned HIGH_CYCLES_HS   = HIGH_HS_CYC,
  parameter int unsigned HIGH_CYCLES_STD  = HIGH_STD_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe_out,
  input  wire logic       std_speed_in,
  input  wire logic       busy_in,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       rx_ack_in,
  output logic            discovered_out,
  output logic            start_out,
  output logic [7:0]      rx_byte_out,
  output logic            rx_valid_out,
  output logic            rx_first_out,
  output logic [3:0]      opcode_out,
  output logic            tx_load_out,
  output logic            tx_nack_out,
  output logic            line_reset_out
);
  if (RESET_CYCLES_HS < 1 || RESET_CYCLES_STD >= (1 << TMR_W) ||
      HIGH_CYCLES_STD >= (1 << TMR_W) || HIGH_CYCLES_HS < 1) begin : g_bad_cycles
    $error("Cycle parameters out of range");
  end

  swl_frame_if frm ();
  swl_line_filter u_filter (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .line_in    (line_in),
    .frm        (frm)
  );

  swl_state_type      st_r,   st_nxt;
  logic [TMR_W-1:0]   tmr_r,  tmr_nxt;
  logic [TMR_W-1:0]   hi_r,   hi_nxt;
  logic [3:0]         bit_r,  bit_nxt;
  logic [7:0]         sh_r,   sh_nxt;
  logic               first_r, first_nxt;
  logic               rd_r,   rd_nxt;
  logic               drv_r,  drv_nxt;
  logic [TMR_W-1:0]   drv_len_r, drv_len_nxt;
  logic               smp_done_r, smp_done_nxt;
  logic               disc_r, disc_nxt;
  logic               start_r, start_nxt;
  logic [7:0]         rxb_r,  rxb_nxt;
  logic               rxv_r,  rxv_nxt;
  logic               rxf_r,  rxf_nxt;
  logic [3:0]         op_r,   op_nxt;
  logic               ld_r,   ld_nxt;
  logic               nack_r, nack_nxt;
  logic               lrst_r, lrst_nxt;
  logic               std_r,  std_nxt;

  logic [TMR_W-1:0] smp_pt;
  logic [TMR_W-1:0] hold0;
  logic [TMR_W-1:0] rst_len;
  logic [TMR_W-1:0] hi_len;

  always_comb begin
    smp_pt  = std_r ? TMR_W'(SAMPLE_STD_CYC) : TMR_W'(SAMPLE_HS_CYC);
    hold0   = std_r ? TMR_W'(HOLD0_STD_CYC) : TMR_W'(HOLD0_HS_CYC);
    rst_len = busy_in ? TMR_W'(DISCHARGE_LOW_NS / NS_PER_CLK)
            : (std_r ? TMR_W'(RESET_CYCLES_STD) : TMR_W'(RESET_CYCLES_HS));
    hi_len  = std_r ? TMR_W'(HIGH_CYCLES_STD) : TMR_W'(HIGH_CYCLES_HS);
  end

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = (tmr_r == '1) ? tmr_r : tmr_r + TMR_W'(1);
    hi_nxt = frm.line_lvl ? ((hi_r == '1) ? hi_r : hi_r + TMR_W'(1)) : '0;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    first_nxt = first_r;
    rd_nxt = rd_r;
    drv_nxt = drv_r;
    drv_len_nxt = drv_len_r;
    smp_done_nxt = smp_done_r;
    disc_nxt = disc_r;
    start_nxt = 1'b0;
    rxb_nxt = rxb_r;
    rxv_nxt = 1'b0;
    rxf_nxt = rxf_r;
    op_nxt = op_r;
    ld_nxt = 1'b0;
    nack_nxt = 1'b0;
    lrst_nxt = 1'b0;
    std_nxt = std_speed_in;
    // Release the line once the programmed drive time has run out
    if (drv_r && tmr_r >= drv_len_r) begin
      drv_nxt = 1'b0;
    end
    // Start or stop: long high time ends any byte and rearms the first-byte flag
    if (frm.line_lvl && hi_r == hi_len - TMR_W'(1) && st_r != SWL_ST_UNDISCOVERED) begin
      start_nxt = 1'b1;
      first_nxt = 1'b1;
      bit_nxt = '0;
      st_nxt = SWL_ST_RX;
    end
    // Long low time is a line reset; come back undiscovered, with std_r cleared for one cycle only
    if (!frm.line_lvl && !drv_r && tmr_r == rst_len) begin
      lrst_nxt = 1'b1;
      std_nxt = 1'b0;
      disc_nxt = 1'b0;
      st_nxt = SWL_ST_UNDISCOVERED;
    end
    if (frm.fall_evt && !drv_r) begin
      tmr_nxt = '0;
      smp_done_nxt = 1'b0;
      case (st_r)
        SWL_ST_UNDISCOVERED: begin
          drv_nxt = 1'b1;
          drv_len_nxt = TMR_W'(ACK_CYC);
          disc_nxt = 1'b1;
          st_nxt = SWL_ST_IDLE;
        end
        SWL_ST_TX: begin
          // Output frame: pull low for a zero, leave released for a one
          if (rd_r && bit_r < BIT_FRAMES_PER_BYTE) begin
            drv_nxt = ~sh_r[7];
            drv_len_nxt = hold0;
          end
        end
        SWL_ST_RX: begin
          // Ninth frame after a received byte: answer acknowledge as a zero frame
          if (bit_r == BIT_FRAMES_PER_BYTE) begin
            drv_nxt = rx_ack_in;
            drv_len_nxt = hold0;
          end
        end
        default: begin
        end
      endcase
    end
    // Sample point inside the frame
    if (!smp_done_r && tmr_r == smp_pt && (st_r == SWL_ST_RX || st_r == SWL_ST_TX)) begin
      smp_done_nxt = 1'b1;
      if (st_r == SWL_ST_RX) begin
        if (bit_r < BIT_FRAMES_PER_BYTE) begin
          sh_nxt = {sh_r[6:0], frm.line_lvl};
          bit_nxt = bit_r + 4'h0001;
          if (bit_r == BIT_FRAMES_PER_BYTE - 4'h0001) begin
            rxb_nxt = {sh_r[6:0], frm.line_lvl};
            rxv_nxt = 1'b1;
            rxf_nxt = first_r;
            if (first_r) begin
              op_nxt = sh_r[6:3];
            end
          end
        end else begin
          bit_nxt = '0;
          first_nxt = 1'b0;
          rd_nxt = rxb_r[0] && rxf_r;
          if (rd_r && !rxf_r) begin
            rd_nxt = 1'b0;
          end
          if (rxb_r[0] && rxf_r && rx_ack_in) begin
            st_nxt = SWL_ST_TX;
            sh_nxt = tx_byte_in;
            ld_nxt = 1'b1;
          end
        end
      end else begin
        if (bit_r < BIT_FRAMES_PER_BYTE) begin
          sh_nxt = {sh_r[6:0], 1'b1};
          bit_nxt = bit_r + 4'h0001;
        end else begin
          // Host acknowledge frame: zero continues the read, one ends it
          bit_nxt = '0;
          if (frm.line_lvl) begin
            nack_nxt = 1'b1;
            st_nxt = SWL_ST_IDLE;
          end else begin
            sh_nxt = tx_byte_in;
            ld_nxt = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r <= SWL_ST_UNDISCOVERED;
      tmr_r <= '1;
      hi_r <= '0;
      bit_r <= '0;
      sh_r <= 8'h00ff;
      first_r <= 1'b1;
      rd_r <= 1'b0;
      drv_r <= 1'b0;
      drv_len_r <= '0;
      smp_done_r <= 1'b1;
      disc_r <= 1'b0;
      start_r <= 1'b0;
      rxb_r <= 8'h0000;
      rxv_r <= 1'b0;
      rxf_r <= 1'b0;
      op_r <= 4'h0000;
      ld_r <= 1'b0;
      nack_r <= 1'b0;
      lrst_r <= 1'b0;
      std_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      hi_r <= hi_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      first_r <= first_nxt;
      rd_r <= rd_nxt;
      drv_r <= drv_nxt;
      drv_len_r <= drv_len_nxt;
      smp_done_r <= smp_done_nxt;
      disc_r <= disc_nxt;
      start_r <= start_nxt;
      rxb_r <= rxb_nxt;
      rxv_r <= rxv_nxt;
      rxf_r <= rxf_nxt;
      op_r <= op_nxt;
      ld_r <= ld_nxt;
      nack_r <= nack_nxt;
      lrst_r <= lrst_nxt;
      std_r <= std_nxt;
    end
  end

  // Open drain: the line is only ever pulled low
  assign line_out       = 1'b0;
  assign line_oe_out    = drv_r;
  assign discovered_out = disc_r;
  assign start_out      = start_r;
  assign rx_byte_out    = rxb_r;
  assign rx_valid_out   = rxv_r;
  assign rx_first_out   = rxf_r;
  assign opcode_out     = op_r;
  assign tx_load_out    = ld_r;
  assign tx_nack_out    = nack_r;
  assign line_reset_out = lrst_r;
endmodule : swl_client
`default_nettype wire

// file: logic/swl_frame_if.sv
// Interface: frame events between the line filter and the frame engine
`timescale 1ns/1ps
`default_nettype none
interface swl_frame_if;
  logic line_lvl;
  logic fall_evt;
  modport filter (output line_lvl, output fall_evt);
  modport engine (input line_lvl, input fall_evt);
endinterface : swl_frame_if
`default_nettype wire

// file: logic/swl_line_filter.sv
// Line filter: three-stage synchroniser, glitch rejection and falling-edge detection
`timescale 1ns/1ps
`default_nettype none
module swl_line_filter
  import swl_pkg::*;
#(
  parameter int unsigned GLITCH_CYCLES = GLITCH_CYC
) (
  input  wire logic    ref_clk_in,
  input  wire logic    reset_in,
  input  wire logic    line_in,
  swl_frame_if.filter  frm
);
  // The run counter is eight bits wide, so longer filters cannot be served
  if (GLITCH_CYCLES < 1 || GLITCH_CYCLES > 255) begin : g_bad_glitch
    $error("GLITCH_CYCLES out of range");
  end

  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  logic       lvl_r;
  logic       lvl_nxt;
  logic       fall_r;
  logic       fall_nxt;

  // A level must persist longer than the glitch width before it is accepted
  always_comb begin
    sync_nxt = {sync_r[1:0], line_in};
    lvl_nxt  = lvl_r;
    fall_nxt = 1'b0;
    run_nxt  = 8'h0000;
    if (sync_r[2] == sync_r[1] && sync_r[2] != lvl_r) begin
      run_nxt = run_r + 8'h0001;
      if (run_r >= 8'(GLITCH_CYCLES)) begin
        lvl_nxt  = sync_r[2];
        fall_nxt = ~sync_r[2];
        run_nxt  = 8'h0000;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sync_r <= 3'h7;
      run_r  <= 8'h0000;
      lvl_r  <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      run_r  <= run_nxt;
      lvl_r  <= lvl_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign frm.line_lvl = lvl_r;
  assign frm.fall_evt = fall_r;
endmodule : swl_line_filter
`default_nettype wire

// file: logic/swl_pkg.sv
// Package: timing constants and types for the single-wire bit-frame link client
package swl_pkg;
  localparam int unsigned CLK_HZ               = 20_000_000;
  localparam int unsigned NS_PER_CLK           = 50;
  // Times in nanoseconds, as printed
  localparam int unsigned GLITCH_FILTER_NS     = 500;
  localparam int unsigned ONE_LOW_MAX_NS       = 2_000;
  localparam int unsigned ZERO_LOW_MIN_NS      = 6_000;
  localparam int unsigned ONE_LOW_MAX_STD_NS   = 8_000;
  localparam int unsigned ZERO_LOW_MIN_STD_NS  = 24_000;
  localparam int unsigned ACK_MIN_NS           = 8_000;
  localparam int unsigned ACK_MAX_NS           = 24_000;
  localparam int unsigned HOLD0_MIN_NS         = 2_000;
  localparam int unsigned HOLD0_MAX_NS         = 6_000;
  localparam int unsigned HOLD0_MIN_STD_NS     = 8_000;
  localparam int unsigned HOLD0_MAX_STD_NS     = 24_000;
  localparam int unsigned RESET_LOW_NS         = 96_000;
  localparam int unsigned RESET_LOW_STD_NS     = 480_000;
  localparam int unsigned DISCHARGE_LOW_NS     = 150_000;
  localparam int unsigned START_STOP_HIGH_NS   = 150_000;
  localparam int unsigned START_STOP_HIGH_STD_NS = 600_000;
  // Cycle counts: least times round up, sample points sit midway
  localparam int unsigned GLITCH_CYC   = (GLITCH_FILTER_NS + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int unsigned SAMPLE_HS_CYC  = (ONE_LOW_MAX_NS + ZERO_LOW_MIN_NS) / 2 / NS_PER_CLK;
  localparam int unsigned SAMPLE_STD_CYC =
    (ONE_LOW_MAX_STD_NS + ZERO_LOW_MIN_STD_NS) / 2 / NS_PER_CLK;
  localparam int unsigned ACK_CYC      = (ACK_MIN_NS + ACK_MAX_NS) / 2 / NS_PER_CLK;
  localparam int unsigned HOLD0_HS_CYC = (HOLD0_MIN_NS + HOLD0_MAX_NS) / 2 / NS_PER_CLK;
  localparam int unsigned HOLD0_STD_CYC =
    (HOLD0_MIN_STD_NS + HOLD0_MAX_STD_NS) / 2 / NS_PER_CLK;
  localparam int unsigned RESET_HS_CYC  = (RESET_LOW_NS + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int unsigned RESET_STD_CYC = (RESET_LOW_STD_NS + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int unsigned HIGH_HS_CYC   = (START_STOP_HIGH_NS + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int unsigned HIGH_STD_CYC  =
    (START_STOP_HIGH_STD_NS + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int unsigned TMR_W = 15;
  localparam logic [3:0]  DEV_TYPE_CODE = 4'h000a;
  localparam logic [3:0]  BIT_FRAMES_PER_BYTE = 4'h0008;

  typedef enum logic [2:0] {
    SWL_ST_UNDISCOVERED,
    SWL_ST_IDLE,
    SWL_ST_RX,
    SWL_ST_TX
  } swl_state_type;
endpackage : swl_pkg
